// File: core/swr_adv_ctrl.sv
/*
 * advanced control register slice of a three-port switch:
 * port 3 queue 0 scheduling select, link change interrupt,
 * pause limit, fiber thresholds, regulator and vlan insertion.
 * assumes the host interface decoder (smi, spi or i2c) hands
 * single-cycle read and write strobes on the core clock.
 *
 */
`timescale 1ns/1ps
`default_nettype none
module swr_adv_ctrl #(
    parameter int unsigned PAUSE_CYCLES = swr_pkg::PAUSE_OFF_CYCLES
) (
    // clock, reset, enable
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // register port from the host interface
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // link levels from the phys and the mii
    input  wire logic       p1_link_analog,
    input  wire logic       p1_link_mii,
    input  wire logic       p2_link_analog,
    input  wire logic       p3_link_mii,
    input  wire logic       p1_mii_sel,
    // scheduler context
    input  wire logic [2:0] p3_q321_sel,
    input  wire logic       global_sched_bit,
    input  wire logic       p3_two_queue,
    // flow control
    input  wire logic       pause_in_effect,
    output logic            fc_invalidate_req,
    // interrupt
    output logic            irq_out_n,
    // port 3 egress scheduling
    output logic            p3_sched_weighted,
    output logic            p3_sched_strict,
    output logic      [3:0] p3_queue_weight,
    // analog and vlan controls
    output logic            p2_fiber_thr_hi,
    output logic            p1_fiber_thr_hi,
    output logic            ldo_disable,
    output logic      [5:0] vlan_insert
);
    // ----------------------------------------------------------
    // link change detection
    // ----------------------------------------------------------
    logic chg_p1a, chg_p1m, chg_p2, chg_p3;
    logic p1_evt, p12_evt;

    swr_link_edge u_p1a (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .link_in  (p1_link_analog),
        .change   (chg_p1a)
    );
    swr_link_edge u_p1m (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .link_in  (p1_link_mii),
        .change   (chg_p1m)
    );
    swr_link_edge u_p2 (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .link_in  (p2_link_analog),
        .change   (chg_p2)
    );
    swr_link_edge u_p3 (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .link_in  (p3_link_mii),
        .change   (chg_p3)
    );

    // port 1 follows whichever interface it currently runs on
    assign p1_evt  = p1_mii_sel ? chg_p1m : chg_p1a;
    // bit 7 only watches the analog side of the copper ports
    assign p12_evt = chg_p1a | chg_p2;

    // ----------------------------------------------------------
    // register state
    // ----------------------------------------------------------
    logic       prio_sel_ff,  nxt_prio_sel;
    logic [7:0] irq_en_ff,    nxt_irq_en;
    logic [7:0] irq_stat_ff,  nxt_irq_stat;
    logic [7:0] pause_lim_ff, nxt_pause_lim;
    logic [7:0] fiber_ff,     nxt_fiber;
    logic [7:0] regctl_ff,    nxt_regctl;
    logic [7:0] vlan_ff,      nxt_vlan;
    logic [7:0] rdata_ff,     nxt_rdata;
    logic [7:0] set_vec,      clr_vec;

    // ----------------------------------------------------------
    // write decode and flag update
    // ----------------------------------------------------------
    always_comb begin
        nxt_prio_sel  = prio_sel_ff;
        nxt_irq_en    = irq_en_ff;
        nxt_pause_lim = pause_lim_ff;
        nxt_fiber     = fiber_ff;
        nxt_regctl    = regctl_ff;
        nxt_vlan      = vlan_ff;
        clr_vec       = 8'h00;
        set_vec       = 8'h00;
        set_vec[swr_pkg::BIT_LC_P12] = p12_evt;
        set_vec[swr_pkg::BIT_LC_P3]  = chg_p3;
        set_vec[swr_pkg::BIT_LC_P2]  = chg_p2;
        set_vec[swr_pkg::BIT_LC_P1]  = p1_evt;
        nxt_irq_stat = irq_stat_ff;
        if (reg_wr) begin
            if (reg_addr == swr_pkg::ADDR_P3Q0_SCHED) begin
                // low bits are read-only, so a write cannot spoil them
                nxt_prio_sel = reg_wdata[swr_pkg::BIT_PRIO_SEL];
            end else if (reg_addr == swr_pkg::ADDR_IRQ_EN) begin
                nxt_irq_en = reg_wdata;
            end else if (reg_addr == swr_pkg::ADDR_IRQ_STAT) begin
                clr_vec = reg_wdata & ~swr_pkg::MASK_LC_RSVD;
                nxt_irq_stat = (irq_stat_ff & ~swr_pkg::MASK_LC_RSVD)
                             | (reg_wdata & swr_pkg::MASK_LC_RSVD);
            end else if (reg_addr == swr_pkg::ADDR_PAUSE_LIM) begin
                nxt_pause_lim = reg_wdata;
            end else if (reg_addr == swr_pkg::ADDR_FIBER_THR) begin
                nxt_fiber = reg_wdata & swr_pkg::MASK_FIB_RW;
            end else if (reg_addr == swr_pkg::ADDR_REG_CTRL) begin
                nxt_regctl = reg_wdata & swr_pkg::MASK_REG_RW;
            end else if (reg_addr == swr_pkg::ADDR_VLAN_INS) begin
                nxt_vlan = reg_wdata & swr_pkg::MASK_VLAN_RW;
            end
        end
        // a new event wins over a clear landing in the same cycle
        nxt_irq_stat = (nxt_irq_stat & ~clr_vec) | set_vec;
    end

    // ----------------------------------------------------------
    // read mux, registered one cycle after the strobe
    // ----------------------------------------------------------
    always_comb begin
        nxt_rdata = rdata_ff;
        if (reg_rd) begin
            if (reg_addr == swr_pkg::ADDR_P3Q0_SCHED) begin
                nxt_rdata = {prio_sel_ff, swr_pkg::RST_P3Q0_RSVD};
            end else if (reg_addr == swr_pkg::ADDR_IRQ_EN) begin
                nxt_rdata = irq_en_ff;
            end else if (reg_addr == swr_pkg::ADDR_IRQ_STAT) begin
                nxt_rdata = irq_stat_ff;
            end else if (reg_addr == swr_pkg::ADDR_PAUSE_LIM) begin
                nxt_rdata = pause_lim_ff;
            end else if (reg_addr == swr_pkg::ADDR_FIBER_THR) begin
                nxt_rdata = fiber_ff;
            end else if (reg_addr == swr_pkg::ADDR_REG_CTRL) begin
                nxt_rdata = regctl_ff;
            end else if (reg_addr == swr_pkg::ADDR_VLAN_INS) begin
                nxt_rdata = vlan_ff;
            end else begin
                nxt_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prio_sel_ff  <= swr_pkg::RST_PRIO_SEL;
            irq_en_ff    <= swr_pkg::RST_IRQ_EN;
            irq_stat_ff  <= swr_pkg::RST_IRQ_STAT;
            pause_lim_ff <= swr_pkg::RST_PAUSE_LIM;
            fiber_ff     <= swr_pkg::RST_FIBER_THR;
            regctl_ff    <= swr_pkg::RST_REG_CTRL;
            vlan_ff      <= swr_pkg::RST_VLAN_INS;
            rdata_ff     <= 8'h00;
        end else if (ce) begin
            prio_sel_ff  <= nxt_prio_sel;
            irq_en_ff    <= nxt_irq_en;
            irq_stat_ff  <= nxt_irq_stat;
            pause_lim_ff <= nxt_pause_lim;
            fiber_ff     <= nxt_fiber;
            regctl_ff    <= nxt_regctl;
            vlan_ff      <= nxt_vlan;
            rdata_ff     <= nxt_rdata;
        end
    end

    // ----------------------------------------------------------
    // interrupt pin and scheduler mode
    // ----------------------------------------------------------
    logic       irq_n_ff,  nxt_irq_n;
    logic       wgt_ff,    nxt_wgt;
    logic       strict_ff, nxt_strict;
    logic [3:0] qw_ff,     nxt_qw;
    logic [3:0] sel_all;

    assign sel_all = {p3_q321_sel, prio_sel_ff};

    always_comb begin
        // only enabled flags may pull the pin
        nxt_irq_n  = ~|(irq_stat_ff & irq_en_ff);
        nxt_wgt    = &sel_all;
        nxt_strict = ~|sel_all & ~global_sched_bit;
        nxt_qw     = 4'h0;
        if (nxt_wgt) begin
            // weight for queue 0; p3_two_queue set gives the same value
            nxt_qw = 4'h1;
            if (p3_two_queue) begin
                nxt_qw = 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_n_ff  <= 1'b1;
            wgt_ff    <= 1'b0;
            strict_ff <= 1'b0;
            qw_ff     <= 4'h0;
        end else if (ce) begin
            irq_n_ff  <= nxt_irq_n;
            wgt_ff    <= nxt_wgt;
            strict_ff <= nxt_strict;
            qw_ff     <= nxt_qw;
        end
    end

    // ----------------------------------------------------------
    // pause limit timer
    // ----------------------------------------------------------
    swr_pause_if pif ();

    // any nonzero value in the limit register turns the limit on
    assign pif.limit_en = |pause_lim_ff;
    assign pif.pause_on = pause_in_effect;

    swr_pause_timer #(
        .LIMIT_CYCLES (PAUSE_CYCLES)
    ) u_pause (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .pif      (pif.tmr)
    );

    // ----------------------------------------------------------
    // outputs
    // ----------------------------------------------------------
    assign reg_rdata         = rdata_ff;
    assign irq_out_n         = irq_n_ff;
    assign fc_invalidate_req = pif.invalidate;
    assign p3_sched_weighted = wgt_ff;
    assign p3_sched_strict   = strict_ff;
    assign p3_queue_weight   = qw_ff;
    assign p2_fiber_thr_hi   = fiber_ff[swr_pkg::BIT_FIB_P2];
    assign p1_fiber_thr_hi   = fiber_ff[swr_pkg::BIT_FIB_P1];
    assign ldo_disable       = regctl_ff[swr_pkg::BIT_LDO_DIS];
    assign vlan_insert       = vlan_ff[swr_pkg::VLAN_BITS-1:0];

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    logic st_wr;
    assign st_wr = reg_wr && reg_addr == swr_pkg::ADDR_IRQ_STAT;

    w1c_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && st_wr && reg_wdata[0] && !p1_evt |=> !irq_stat_ff[0])
        else $error("status bit 0 not cleared by write of one");
    w0_keep_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && irq_stat_ff[2] && !(st_wr && reg_wdata[2]) |=> irq_stat_ff[2])
        else $error("status bit 2 lost without a write of one");
    set_wins_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && chg_p3 |=> irq_stat_ff[2])
        else $error("port 3 change not flagged");
    p12_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && (chg_p1a || chg_p2) |=> irq_stat_ff[7] && (!chg_p2 || irq_stat_ff[1]))
        else $error("copper change not flagged");
    p1_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && p1_mii_sel && chg_p1m |=> irq_stat_ff[0])
        else $error("port 1 mii change not flagged");
    irq_gate_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && irq_en_ff == 8'h00 |=> irq_out_n)
        else $error("interrupt asserted with all enables clear");
    irq_pull_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && (irq_stat_ff & irq_en_ff) != 8'h00 |=> !irq_out_n)
        else $error("interrupt not asserted for enabled flag");
    sched_mode_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && sel_all == 4'hF |=> p3_sched_weighted && !p3_sched_strict)
        else $error("weighted mode not selected");
    strict_mode_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && sel_all == 4'h0 && !global_sched_bit |=> p3_sched_strict)
        else $error("strict mode not selected");

    // fiber, regulator and vlan writes reach their outputs one edge later
    logic en_wr, fib_wr, ldo_wr, vlan_wr, sel_rd;
    assign en_wr   = reg_wr && reg_addr == swr_pkg::ADDR_IRQ_EN;
    assign fib_wr  = reg_wr && reg_addr == swr_pkg::ADDR_FIBER_THR;
    assign ldo_wr  = reg_wr && reg_addr == swr_pkg::ADDR_REG_CTRL;
    assign vlan_wr = reg_wr && reg_addr == swr_pkg::ADDR_VLAN_INS;
    assign sel_rd  = reg_rd && reg_addr == swr_pkg::ADDR_P3Q0_SCHED;

    en_write_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && en_wr |=> irq_en_ff == $past(reg_wdata))
        else $error("enable write lost");

    fiber_out_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && fib_wr |=> {p2_fiber_thr_hi, p1_fiber_thr_hi, 6'h00} == ($past(reg_wdata) & swr_pkg::MASK_FIB_RW))
        else $error("fiber threshold not applied");
    ldo_out_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && ldo_wr |=> {1'h0, ldo_disable, 6'h00} == ($past(reg_wdata) & swr_pkg::MASK_REG_RW))
        else $error("regulator disable not applied");
    vlan_out_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && vlan_wr |=> {2'h0, vlan_insert} == ($past(reg_wdata) & swr_pkg::MASK_VLAN_RW))
        else $error("vlan insertion not applied");

    sel_read_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && sel_rd |=> reg_rdata == {$past(prio_sel_ff), swr_pkg::RST_P3Q0_RSVD})
        else $error("priority select read back wrong");

    p2_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && chg_p2 |=> irq_stat_ff[swr_pkg::BIT_LC_P2])
        else $error("port 2 change not flagged");
    p1a_flag_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && !p1_mii_sel && chg_p1a |=> irq_stat_ff[swr_pkg::BIT_LC_P1])
        else $error("port 1 analog change not flagged");
endmodule
`default_nettype wire

// File: core/swr_link_edge.sv
/*
 * link level synchroniser with change detector.
 * assumes the level comes from outside the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module swr_link_edge (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic ce,
    // link level and change pulse
    input  wire logic link_in,
    output logic      change
);
    logic s1_ff, s2_ff, s3_ff, state_ff, chg_ff;
    logic nxt_state, nxt_chg;

    // --------------------------------------------------------
    // a change counts once stages two and three agree
    // --------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_chg   = 1'b0;
        if (s2_ff == s3_ff && s3_ff != state_ff) begin
            nxt_state = s3_ff;
            nxt_chg   = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s1_ff    <= 1'b0;
            s2_ff    <= 1'b0;
            s3_ff    <= 1'b0;
            state_ff <= 1'b0;
            chg_ff   <= 1'b0;
        end else if (ce) begin
            s1_ff    <= link_in;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            state_ff <= nxt_state;
            chg_ff   <= nxt_chg;
        end
    end

    assign change = chg_ff;

    chg_agree_a: assert property (@(posedge core_clk) disable iff (rst)
        ce && $rose(chg_ff) |-> $past(s2_ff) == $past(s3_ff))
        else $error("link change without settled input");
endmodule
`default_nettype wire

// File: core/swr_pause_if.sv
/*
 * carrier between the register core and the pause limit timer.
 * assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface swr_pause_if;
    logic limit_en;
    logic pause_on;
    logic invalidate;
    modport ctl (output limit_en, output pause_on, input invalidate);
    modport tmr (input limit_en, input pause_on, output invalidate);
endinterface
`default_nettype wire

// File: core/swr_pause_timer.sv
/*
 * pause duration limiter: asks for flow control to be dropped
 * once pause has lasted the limit time.
 * assumes pause_on is a level on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module swr_pause_timer #(
    parameter int unsigned LIMIT_CYCLES = swr_pkg::PAUSE_OFF_CYCLES
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic ce,
    // control from the register core
    swr_pause_if.tmr  pif
);
    localparam int CW = $clog2(LIMIT_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(LIMIT_CYCLES - 1);

    swr_pkg::swr_pause_st_t st_ff, nxt_st;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic          req_ff, nxt_req;

    // --------------------------------------------------------
    // timer state machine
    // --------------------------------------------------------
    always_comb begin
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff;
        nxt_req = 1'b0;
        case (st_ff)
            swr_pkg::PT_IDLE: begin
                nxt_cnt = '0;
                if (pif.limit_en && pif.pause_on) begin
                    nxt_st = swr_pkg::PT_COUNT;
                end
            end
            swr_pkg::PT_COUNT: begin
                nxt_cnt = cnt_ff + CW'(1);
                if (!pif.limit_en || !pif.pause_on) begin
                    nxt_st = swr_pkg::PT_IDLE;
                end else if (cnt_ff == LAST) begin
                    nxt_st  = swr_pkg::PT_EXPIRED;
                    nxt_req = 1'b1;
                end
            end
            swr_pkg::PT_EXPIRED: begin
                // request holds until pause ends or limit is off
                nxt_req = pif.limit_en && pif.pause_on;
                if (!nxt_req) begin
                    nxt_st = swr_pkg::PT_IDLE;
                end
            end
            default: nxt_st = swr_pkg::PT_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_ff  <= swr_pkg::PT_IDLE;
            cnt_ff <= '0;
            req_ff <= 1'b0;
        end else if (ce) begin
            st_ff  <= nxt_st;
            cnt_ff <= nxt_cnt;
            req_ff <= nxt_req;
        end
    end

    assign pif.invalidate = req_ff;

    no_limit_a: assert property (@(posedge core_clk) disable iff (rst)
        !pif.limit_en |=> !req_ff)
        else $error("invalidate requested with limit disabled");
    req_time_a: assert property (@(posedge core_clk) disable iff (rst)
        $rose(req_ff) |-> $past(cnt_ff) == LAST)
        else $error("invalidate request at wrong count");
endmodule
`default_nettype wire

// File: core/swr_pkg.sv
/*
 * constants for the switch advanced control register slice:
 * offsets, field positions, reset values, timing and the
 * pause timer state type.
 * assumes a 100 MHz core clock and an 8-bit register port.
 */
`default_nettype none
package swr_pkg;
    // ----------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------
    localparam logic [7:0] ADDR_P3Q0_SCHED = 8'hBA;
    localparam logic [7:0] ADDR_IRQ_EN     = 8'hBB;
    localparam logic [7:0] ADDR_IRQ_STAT   = 8'hBC;
    localparam logic [7:0] ADDR_PAUSE_LIM  = 8'hBD;
    localparam logic [7:0] ADDR_FIBER_THR  = 8'hC0;
    localparam logic [7:0] ADDR_REG_CTRL   = 8'hC1;
    localparam logic [7:0] ADDR_VLAN_INS   = 8'hC2;

    // ----------------------------------------------------------
    // reset values
    // ----------------------------------------------------------
    localparam logic       RST_PRIO_SEL   = 1'h1;
    localparam logic [6:0] RST_P3Q0_RSVD  = 7'h01;
    localparam logic [7:0] RST_IRQ_EN     = 8'h00;
    localparam logic [7:0] RST_IRQ_STAT   = 8'h00;
    localparam logic [7:0] RST_PAUSE_LIM  = 8'h00;
    localparam logic [7:0] RST_FIBER_THR  = 8'h00;
    localparam logic [7:0] RST_REG_CTRL   = 8'h00;
    localparam logic [7:0] RST_VLAN_INS   = 8'h00;

    // ----------------------------------------------------------
    // field positions and writable masks
    // ----------------------------------------------------------
    localparam int         BIT_PRIO_SEL  = 7;
    localparam int         BIT_LC_P12    = 7;
    localparam int         BIT_LC_P3     = 2;
    localparam int         BIT_LC_P2     = 1;
    localparam int         BIT_LC_P1     = 0;
    localparam logic [7:0] MASK_LC_RSVD  = 8'h78;
    localparam int         BIT_FIB_P2    = 7;
    localparam int         BIT_FIB_P1    = 6;
    localparam logic [7:0] MASK_FIB_RW   = 8'hC0;
    localparam int         BIT_LDO_DIS   = 6;
    localparam logic [7:0] MASK_REG_RW   = 8'h40;
    localparam logic [7:0] MASK_VLAN_RW  = 8'h3F;
    localparam int         VLAN_BITS     = 6;

    // ----------------------------------------------------------
    // timing
    // ----------------------------------------------------------
    localparam int unsigned CLK_HZ           = 100_000_000;
    localparam int unsigned PAUSE_OFF_MS     = 160;
    localparam int unsigned PAUSE_OFF_CYCLES = PAUSE_OFF_MS * (CLK_HZ / 1000);

    // ----------------------------------------------------------
    // types
    // ----------------------------------------------------------
    typedef enum logic [1:0] {
        PT_IDLE    = 2'b00,
        PT_COUNT   = 2'b01,
        PT_EXPIRED = 2'b10
    } swr_pause_st_t;
endpackage
`default_nettype wire

// File: verification/swr_host_model.sv
/*
 * host processor model: strobed reads and writes on the register port.
 * assumes the slice's core clock and one access at a time.
 */
`timescale 1ns/1ps
`default_nettype none
module swr_host_model (
    // clock
    input  wire logic       core_clk,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // reserved bits stay at reset value, except where a refusal is probed
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        #1;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// File: verification/tb_switch_adv_ctrl_regs_186_194.sv
/*
 * register-level testbench of the advanced control slice.
 * assumes the pause limit is shortened to 8 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_switch_adv_ctrl_regs_186_194;
    logic core_clk = 1'b0, rst = 1'b1, p1_mii_sel = 1'b0, global_sched_bit = 1'b0, pause_in_effect = 1'b0;
    logic ce = 1'b1, p3_two_queue = 1'b0;
    logic [3:0] lnk = 4'h0;
    logic [2:0] p3_q321_sel = 3'h0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, fc_req, irq_out_n, s_w, s_s, f2, f1, ldo;
    logic [3:0] wgt;
    logic [5:0] vins;
    int errors = 0, checks_done = 0, cyc = 0;
    logic [7:0] ra [8] = '{8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hC0, 8'hC1, 8'hC2, 8'hBE};
    logic [7:0] rf [8] = '{8'h81, 8'hFF, 8'h00, 8'hFF, 8'hC0, 8'h40, 8'h3F, 8'h00};
    logic [3:0] ep [4] = '{4'h1, 4'h4, 4'h8, 4'h2};
    logic       es [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic [7:0] ee [4] = '{8'h81, 8'h82, 8'h04, 8'h01};
    always #5 core_clk = ~core_clk;
    swr_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    swr_adv_ctrl #(.PAUSE_CYCLES(8)) DUT (.core_clk(core_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .p1_link_analog(lnk[0]), .p1_link_mii(lnk[1]), .p2_link_analog(lnk[2]), .p3_link_mii(lnk[3]),
        .p1_mii_sel(p1_mii_sel), .p3_q321_sel(p3_q321_sel), .global_sched_bit(global_sched_bit),
        .p3_two_queue(p3_two_queue), .pause_in_effect(pause_in_effect), .fc_invalidate_req(fc_req),
        .irq_out_n(irq_out_n), .p3_sched_weighted(s_w), .p3_sched_strict(s_s), .p3_queue_weight(wgt),
        .p2_fiber_thr_hi(f2), .p1_fiber_thr_hi(f1), .ldo_disable(ldo), .vlan_insert(vins));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ceiling well above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            host.rd(ra[i], d);
            chk("reset value", (i == 0) ? 8'h81 : 8'h00, d);
        end
        for (int i = 0; i < 8; i++) begin
            host.wr(ra[i], (i == 2) ? 8'h87 : 8'hFF);
            host.rd(ra[i], d);
            chk("write mask", rf[i], d);
        end
        chk("controls on", 8'hFF, {f2, f1, vins});
        chk("ldo off", 8'h01, {7'h0, ldo});
        for (int i = 0; i < 8; i++)
            host.wr(ra[i], 8'h00);
        chk("controls off", 8'h00, {ldo, f2, f1, vins[4:0]});
        chk("vlan off", 8'h00, {2'h0, vins});
        chk("strict", 8'h10, {2'h0, s_w, s_s, wgt});
        global_sched_bit <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("global blocks strict", 8'h00, {2'h0, s_w, s_s, wgt});
        host.wr(8'hBA, 8'h81);
        p3_q321_sel <= 3'h7;
        global_sched_bit <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("weighted", 8'h21, {2'h0, s_w, s_s, wgt});
        p3_two_queue <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("weighted two queues", 8'h21, {2'h0, s_w, s_s, wgt});
        p3_q321_sel <= 3'h3;
        repeat (3) @(posedge core_clk);
        chk("mixed selects", 8'h00, {2'h0, s_w, s_s, wgt});
        $display("test registers and scheduler done");
        host.wr(8'hBB, 8'h87);
        for (int i = 0; i < 4; i++) begin
            p1_mii_sel <= es[i];
            repeat (8) @(posedge core_clk);
            host.wr(8'hBC, 8'h87);
            lnk <= lnk ^ ep[i];
            repeat (8) @(posedge core_clk);
            host.rd(8'hBC, d);
            chk("link status", ee[i], d);
            chk("irq low", 8'h00, {7'h0, irq_out_n});
        end
        host.wr(8'hBC, 8'h00);
        host.rd(8'hBC, d);
        chk("write zero keeps", 8'h01, d);
        host.wr(8'hBB, 8'h00);
        repeat (2) @(posedge core_clk);
        chk("irq masked", 8'h01, {7'h0, irq_out_n});
        host.wr(8'hBC, 8'h01);
        host.rd(8'hBC, d);
        chk("write one clears", 8'h00, d);
        $display("test link change done");
        host.wr(8'hBD, 8'h01);
        pause_in_effect <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("pause early", 8'h00, {7'h0, fc_req});
        repeat (10) @(posedge core_clk);
        chk("pause limit", 8'h01, {7'h0, fc_req});
        pause_in_effect <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("pause end", 8'h00, {7'h0, fc_req});
        host.wr(8'hBD, 8'h00);
        pause_in_effect <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk("limit off", 8'h00, {7'h0, fc_req});
        pause_in_effect <= 1'b0;
        $display("test pause limit done");
        ce <= 1'b0;
        lnk <= lnk ^ 4'h8;
        host.wr(8'hBB, 8'hFF);
        lnk <= lnk ^ 4'h8;
        repeat (2) @(posedge core_clk);
        ce <= 1'b1;
        host.rd(8'hBB, d);
        chk("frozen write", 8'h00, d);
        host.rd(8'hBC, d);
        chk("frozen link", 8'h00, d);
        $display("test clock enable done");
        complete_run();
    end
endmodule
`default_nettype wire
